// >>> rtl/quad_tx_pkg.sv
package quad_tx_pkg;

    // Fixed device geometry and bus widths
    localparam int NUM_CHAN = 4;
    localparam int ADDR_W   = 4;
    localparam int DATA_W   = 32;

    // Register offsets
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_MASK   = 4'h8;
    localparam logic [3:0] ADDR_FLAGS  = 4'hc;

    // Reset values
    localparam logic [3:0]  CTRL_RESET   = 4'h0;
    localparam logic [11:0] STATUS_RESET = 12'h000;
    localparam logic [11:0] MASK_RESET   = 12'h000;

    // Field positions
    localparam int CTRL_BIST_LSB    = 0;
    localparam int STAT_PAR_LSB     = 0;
    localparam int STAT_BIST_LSB    = 4;
    localparam int STAT_FAULT_LSB   = 8;
    localparam int FLAGS_ERR_LSB    = 0;
    localparam int FLAGS_ACTIVE_LSB = 4;
    localparam int FLAGS_HALF_LSB   = 5;
    localparam int FLAGS_SEL_LSB    = 6;

    // Character times per self-test pass
    localparam int         BIST_PERIOD = 511;
    localparam logic [8:0] BIST_LAST   = 9'(BIST_PERIOD - 1);

    // Three-level select codes
    localparam logic [1:0] LVL_LOW  = 2'h0;
    localparam logic [1:0] LVL_MID  = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;

    // Control code values in encoded mode
    localparam logic [1:0] CODE_DATA    = 2'h0;
    localparam logic [1:0] CODE_SPECIAL = 2'h1;
    localparam logic [1:0] CODE_FILL    = 2'h2;
    localparam logic [1:0] CODE_SYNC    = 2'h3;

    typedef enum logic [2:0] {
        KIND_DATA,
        KIND_SPECIAL,
        KIND_FILL,
        KIND_SYNC,
        KIND_RAW,
        KIND_VIOL
    } char_kind_e;

    typedef struct packed {
        logic [1:0] ctrl;
        logic [7:0] data;
        logic       par;
    } in_char_s;

    typedef struct packed {
        logic     special;
        in_char_s ch;
    } buf_word_s;

    typedef struct packed {
        char_kind_e kind;
        logic [9:0] bits;
    } enc_out_s;

    typedef struct packed {
        logic                    ref_clk;
        logic [NUM_CHAN-1:0]     chan_clk;
        in_char_s [NUM_CHAN-1:0] chars;
        logic                    special;
        logic [1:0]              clk_sel;
        logic                    half_rate;
        logic [1:0]              mode;
        logic [1:0]              par_ctl;
        logic                    phase_rst_n;
    } pins_s;

    localparam pins_s PINS_RESET = '0;

endpackage : quad_tx_pkg

// >>> rtl/tx_chan_path.sv
`timescale 1ns/100ps
`default_nettype none

module tx_chan_path #(
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_rst_n,
    // Configuration
    input  wire logic [1:0]             i_mode,
    input  wire logic [1:0]             i_par_ctl,
    input  wire logic                   i_buf_active,
    input  wire logic                   i_bist_en,
    // Captured input and timing
    input  wire logic                   i_cap,
    input  wire quad_tx_pkg::in_char_s  i_char,
    input  wire logic                   i_special,
    input  wire logic                   i_char_tick,
    input  wire logic                   i_phase_rst,
    // Encoder side
    output var  quad_tx_pkg::enc_out_s  o_out,
    output logic                        o_out_valid,
    output logic                        o_error_flag,
    // Events
    output logic                        o_par_evt,
    output logic                        o_bist_evt,
    output logic                        o_fault_evt
);

    localparam int         PW   = $clog2(DEPTH);
    localparam logic [PW:0] HALF = (PW+1)'(DEPTH / 2);
    localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("DEPTH must be a power of two and at least 2");
    end

    quad_tx_pkg::buf_word_s mem [DEPTH];
    quad_tx_pkg::buf_word_s cur;
    quad_tx_pkg::enc_out_s  next_out;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0]   occ;
    logic [8:0]    bist_cnt;
    logic          par_q;
    logic          bist_q;
    logic          fault;
    logic          empty, full, push, pop, under, over;
    logic          proc, proc_valid, recenter, enc_on, par_bad, sync_sent;
    logic [9:0]    checked;

    // Phase-align buffer occupancy
    assign empty    = (occ == '0);
    assign full     = (occ == FULL);
    assign push     = i_buf_active & i_cap & ~full;
    assign pop      = i_buf_active & i_char_tick & ~empty;
    assign under    = i_buf_active & i_char_tick & empty;
    assign over     = i_buf_active & i_cap & full;
    assign recenter = i_buf_active & i_phase_rst;
    assign proc     = i_buf_active ? i_char_tick : i_cap;
    assign proc_valid = i_buf_active ? pop : i_cap;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= '{special: i_special, ch: i_char};
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr <= HALF[PW-1:0];
            rd_ptr <= '0;
            occ    <= HALF;
        end else if (recenter) begin
            wr_ptr <= HALF[PW-1:0];
            rd_ptr <= '0;
            occ    <= HALF;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                occ <= occ + 1'b1;
            end else if (pop && !push) begin
                occ <= occ - 1'b1;
            end
        end
    end

    // Character classification and parity check
    always_comb begin
        cur = i_buf_active ? mem[rd_ptr]
                           : '{special: i_special, ch: i_char};
        enc_on  = (i_mode != quad_tx_pkg::LVL_LOW);
        checked = (i_par_ctl == quad_tx_pkg::LVL_HIGH)
                ? {cur.ch.ctrl, cur.ch.data}
                : {2'b00, cur.ch.data};
        par_bad = (i_par_ctl != quad_tx_pkg::LVL_LOW)
                & ~(^{checked, cur.ch.par});
        next_out.bits = {cur.ch.ctrl, cur.ch.data};
        if (par_bad) begin
            next_out.kind = quad_tx_pkg::KIND_VIOL;
        end else if (!enc_on) begin
            next_out.kind = quad_tx_pkg::KIND_RAW;
        end else begin
            unique case (cur.ch.ctrl)
                quad_tx_pkg::CODE_DATA:    next_out.kind = quad_tx_pkg::KIND_DATA;
                quad_tx_pkg::CODE_SPECIAL: next_out.kind = quad_tx_pkg::KIND_SPECIAL;
                quad_tx_pkg::CODE_FILL:    next_out.kind = quad_tx_pkg::KIND_FILL;
                quad_tx_pkg::CODE_SYNC:    next_out.kind = cur.special
                                           ? quad_tx_pkg::KIND_SYNC
                                           : quad_tx_pkg::KIND_SPECIAL;
            endcase
        end
    end

    assign sync_sent = proc_valid & (next_out.kind == quad_tx_pkg::KIND_SYNC);

    // Output character register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_out       <= '{kind: quad_tx_pkg::KIND_DATA, bits: 10'h000};
            o_out_valid <= 1'b0;
        end else begin
            o_out_valid <= proc_valid;
            if (proc_valid) begin
                o_out <= next_out;
            end
        end
    end

    // One-character parity pulse
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            par_q <= 1'b0;
        end else if (proc) begin
            par_q <= proc_valid & par_bad;
        end
    end

    // Self-test pass counter
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bist_cnt <= '0;
            bist_q   <= 1'b0;
        end else if (!i_bist_en) begin
            bist_cnt <= '0;
            bist_q   <= 1'b0;
        end else if (proc) begin
            bist_q   <= (bist_cnt == quad_tx_pkg::BIST_LAST);
            bist_cnt <= (bist_cnt == quad_tx_pkg::BIST_LAST)
                      ? '0 : bist_cnt + 1'b1;
        end
    end

    // Sticky buffer fault, set wins over clear
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fault <= 1'b0;
        end else if (under || over) begin
            fault <= 1'b1;
        end else if (sync_sent || recenter) begin
            fault <= 1'b0;
        end
    end

    assign o_error_flag = (i_bist_en ? bist_q : par_q) | fault;
    assign o_par_evt    = proc_valid & par_bad;
    assign o_bist_evt   = i_bist_en & proc
                        & (bist_cnt == quad_tx_pkg::BIST_LAST);
    assign o_fault_evt  = under | over;

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    par_flag_a: assert property (proc_valid && par_bad |=> par_q)
        else $error("parity pulse missing");
    par_hold_a: assert property (!proc |=> $stable(par_q))
        else $error("parity pulse length wrong");
    viol_sub_a: assert property (proc_valid && par_bad
        |=> o_out.kind == quad_tx_pkg::KIND_VIOL)
        else $error("bad character not replaced");
    bist_wrap_a: assert property (i_bist_en && proc
        && bist_cnt == quad_tx_pkg::BIST_LAST |=> bist_q && bist_cnt == '0)
        else $error("self-test pass not flagged");
    buf_pass_a: assert property (!i_buf_active && i_cap
        |=> o_out_valid) else $error("unbuffered character not passed");
    fault_hold_a: assert property (fault && !sync_sent && !recenter
        |=> fault) else $error("buffer fault dropped early");
    raw_char_a: assert property (proc_valid && !enc_on && !par_bad
        |=> o_out.kind == quad_tx_pkg::KIND_RAW
        && o_out.bits == $past(next_out.bits))
        else $error("raw character wrong");
    fill_kind_a: assert property (proc_valid && enc_on && !par_bad
        && cur.ch.ctrl == quad_tx_pkg::CODE_FILL
        |=> o_out.kind == quad_tx_pkg::KIND_FILL)
        else $error("fill code not honoured");
    par_off_a: assert property (proc
        && i_par_ctl == quad_tx_pkg::LVL_LOW |=> !par_q)
        else $error("parity flagged while off");

    fault_seen_c: cover property (over ##[1:100] sync_sent);
    viol_seen_c:  cover property (proc_valid && par_bad);
    bist_seen_c:  cover property (o_bist_evt);

endmodule : tx_chan_path

`default_nettype wire

// >>> rtl/quad_tx_input_parity_check.sv
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module quad_tx_input_parity_check #(
    parameter int BUF_DEPTH = 4
) (
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    // Clock pins
    input  wire logic                 i_reference_clock,
    input  wire logic [3:0]           i_chan_input_clock,
    // Character pins
    input  wire logic [3:0][1:0]      i_chan_ctrl_code,
    input  wire logic [3:0][7:0]      i_chan_char_byte,
    input  wire logic [3:0]           i_chan_odd_parity_in,
    input  wire logic                 i_special_char_select,
    // Static control pins
    input  wire logic [1:0]           i_input_clock_select,
    input  wire logic                 i_half_rate_select,
    input  wire logic [1:0]           i_encoder_mode_setting,
    input  wire logic [1:0]           i_parity_check_control,
    input  wire logic                 i_phase_align_reset_n,
    // Register port
    input  wire logic [3:0]           i_addr,
    input  wire logic [31:0]          i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output logic [31:0]               o_rdata,
    // Encoder side
    output var quad_tx_pkg::enc_out_s [3:0] o_chan_out,
    output logic [3:0]                o_chan_out_valid,
    output logic [3:0]                o_chan_error_flag,
    // Interrupt
    output logic                      o_irq
);

    localparam int NC = quad_tx_pkg::NUM_CHAN;

    quad_tx_pkg::pins_s raw, s1, s2, s3, filt, prev;
    quad_tx_pkg::in_char_s [NC-1:0] cap_char;
    logic [NC-1:0] cap_valid, cap_tick, chan_rise;
    logic [NC-1:0] par_evt, bist_evt, fault_evt;
    logic          cap_special, ref_rise, ref_fall, char_tick;
    logic          buf_active, phase_rst;
    logic [3:0]    ctrl;
    logic [11:0]   status, mask, events;

    // Pin bundle
    always_comb begin
        raw.ref_clk     = i_reference_clock;
        raw.chan_clk    = i_chan_input_clock;
        raw.special     = i_special_char_select;
        raw.clk_sel     = i_input_clock_select;
        raw.half_rate   = i_half_rate_select;
        raw.mode        = i_encoder_mode_setting;
        raw.par_ctl     = i_parity_check_control;
        raw.phase_rst_n = i_phase_align_reset_n;
        for (int i = 0; i < NC; i++) begin
            raw.chars[i] = '{ctrl: i_chan_ctrl_code[i],
                             data: i_chan_char_byte[i],
                             par:  i_chan_odd_parity_in[i]};
        end
    end

    // Three-stage synchroniser, value taken when stages two and three agree
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1   <= quad_tx_pkg::PINS_RESET;
            s2   <= quad_tx_pkg::PINS_RESET;
            s3   <= quad_tx_pkg::PINS_RESET;
            filt <= quad_tx_pkg::PINS_RESET;
            prev <= quad_tx_pkg::PINS_RESET;
        end else begin
            s1   <= raw;
            s2   <= s1;
            s3   <= s2;
            filt <= quad_tx_pkg::pins_s'((s3 & ~(s2 ^ s3))
                                        | (filt & (s2 ^ s3)));
            prev <= filt;
        end
    end

    // Clock edges and character timing
    assign ref_rise   = filt.ref_clk & ~prev.ref_clk;
    assign ref_fall   = ~filt.ref_clk & prev.ref_clk;
    assign char_tick  = ref_rise | (filt.half_rate & ref_fall);
    assign chan_rise  = filt.chan_clk & ~prev.chan_clk;
    assign buf_active = (filt.clk_sel != quad_tx_pkg::LVL_LOW)
                      | filt.half_rate;
    assign phase_rst  = ref_rise & ~filt.phase_rst_n;

    // Input register clock choice per channel
    always_comb begin
        for (int i = 0; i < NC; i++) begin
            unique case (filt.clk_sel)
                quad_tx_pkg::LVL_LOW:  cap_tick[i] = char_tick;
                quad_tx_pkg::LVL_MID:  cap_tick[i] = chan_rise[i];
                quad_tx_pkg::LVL_HIGH: cap_tick[i] = chan_rise[0];
                default:               cap_tick[i] = 1'b0;
            endcase
        end
    end

    // Input register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cap_char  <= '0;
            cap_valid <= '0;
        end else begin
            cap_valid <= cap_tick;
            for (int i = 0; i < NC; i++) begin
                if (cap_tick[i]) begin
                    cap_char[i] <= filt.chars[i];
                end
            end
        end
    end

    // Shared special select follows channel A's input register clock
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cap_special <= 1'b0;
        end else if (cap_tick[0]) begin
            cap_special <= filt.special;
        end
    end

    // Channel paths
    for (genvar g = 0; g < NC; g++) begin : g_chan
        tx_chan_path #(
            .DEPTH (BUF_DEPTH)
        ) u_path (
            .i_clk        (i_clk),
            .i_rst_n      (i_rst_n),
            .i_mode       (filt.mode),
            .i_par_ctl    (filt.par_ctl),
            .i_buf_active (buf_active),
            .i_bist_en    (ctrl[quad_tx_pkg::CTRL_BIST_LSB + g]),
            .i_cap        (cap_valid[g]),
            .i_char       (cap_char[g]),
            .i_special    (cap_special),
            .i_char_tick  (char_tick),
            .i_phase_rst  (phase_rst),
            .o_out        (o_chan_out[g]),
            .o_out_valid  (o_chan_out_valid[g]),
            .o_error_flag (o_chan_error_flag[g]),
            .o_par_evt    (par_evt[g]),
            .o_bist_evt   (bist_evt[g]),
            .o_fault_evt  (fault_evt[g])
        );
    end

    // Register decode
    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction : hit

    assign events = {fault_evt, bist_evt, par_evt};

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl <= quad_tx_pkg::CTRL_RESET;
            mask <= quad_tx_pkg::MASK_RESET;
        end else if (i_wr) begin
            if (hit(i_addr, quad_tx_pkg::ADDR_CTRL)) begin
                ctrl <= i_wdata[3:0];
            end
            if (hit(i_addr, quad_tx_pkg::ADDR_MASK)) begin
                mask <= i_wdata[11:0];
            end
        end
    end

    // Sticky status, write one to clear, new events win
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            status <= quad_tx_pkg::STATUS_RESET;
        end else if (i_wr && hit(i_addr, quad_tx_pkg::ADDR_STATUS)) begin
            status <= (status & ~i_wdata[11:0]) | events;
        end else begin
            status <= status | events;
        end
    end

    assign o_irq = |(status & mask);

    // Read data for one cycle after the strobe
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= '0;
        end else if (!i_rd) begin
            o_rdata <= '0;
        end else if (hit(i_addr, quad_tx_pkg::ADDR_CTRL)) begin
            o_rdata <= {28'h0000000, ctrl};
        end else if (hit(i_addr, quad_tx_pkg::ADDR_STATUS)) begin
            o_rdata <= {20'h00000, status};
        end else if (hit(i_addr, quad_tx_pkg::ADDR_MASK)) begin
            o_rdata <= {20'h00000, mask};
        end else if (hit(i_addr, quad_tx_pkg::ADDR_FLAGS)) begin
            o_rdata <= {24'h000000, filt.clk_sel, filt.half_rate,
                        buf_active, o_chan_error_flag};
        end else begin
            o_rdata <= '0;
        end
    end

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    own_clk_a: assert property (filt.clk_sel == quad_tx_pkg::LVL_MID
        && chan_rise[2] |=> cap_valid[2]
        && cap_char[2] == $past(filt.chars[2]))
        else $error("own clock capture missed");
    sc_hold_a: assert property (filt.clk_sel == quad_tx_pkg::LVL_MID
        && !chan_rise[0] |=> $stable(cap_special))
        else $error("special select moved off clock A");
    half_edge_a: assert property (filt.half_rate && ref_fall
        && filt.clk_sel == quad_tx_pkg::LVL_LOW |=> cap_valid[1])
        else $error("falling edge capture missed");
    a_clock_a: assert property (chan_rise[0]
        && filt.clk_sel == quad_tx_pkg::LVL_HIGH |=> cap_valid == 4'hf)
        else $error("clock A did not load all channels");
    irq_level_a: assert property (|(events & mask) && !i_wr
        |=> ##[0:1] o_irq) else $error("interrupt not raised");

    half_mode_c: cover property (filt.half_rate && ref_fall ##1 cap_valid[0]);
    mid_mode_c:  cover property (filt.clk_sel == quad_tx_pkg::LVL_MID
        && chan_rise[3]);

endmodule : quad_tx_input_parity_check

`default_nettype wire

// >>> tb/tx_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module tx_host_model (
    // Reference clock and character pins
    output logic            o_ref_clk,
    output logic [3:0][1:0] o_ctrl,
    output logic [3:0][7:0] o_byte,
    output logic [3:0]      o_par,
    output logic            o_special
);
    initial begin
        o_ref_clk = 1'b0;
        o_ctrl    = '0;
        o_byte    = '0;
        o_par     = '1;
        o_special = 1'b0;
    end

    // One character per clock pulse, data stable across the rise
    task automatic send(input logic [1:0] c, input logic [7:0] d,
                        input logic [1:0] pc, input logic bad,
                        input logic s);
        o_ctrl    <= {4{c}};
        o_byte    <= {4{d}};
        o_par     <= {4{(pc[1] ? ~^{c, d} : ~^d) ^ bad}};
        o_special <= s;
        #100 o_ref_clk <= 1'b1;
        #100 o_ref_clk <= 1'b0;
    endtask : send
endmodule : tx_host_model

`default_nettype wire

// >>> tb/quad_tx_input_parity_check_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module quad_tx_input_parity_check_tb_top;
    logic                        i_clk;
    logic                        i_rst_n;
    logic                        ref_clk;
    logic [3:0][1:0]             ctrl;
    logic [3:0][7:0]             chr;
    logic [3:0]                  par;
    logic                        special;
    logic [1:0]                  mode;
    logic [1:0]                  par_ctl;
    logic [1:0]                  sel;
    logic                        half;
    logic                        prst_n;
    logic [3:0]                  addr;
    logic [31:0]                 wdata;
    logic                        reg_wr;
    logic                        reg_rd;
    logic [31:0]                 rdata;
    quad_tx_pkg::enc_out_s [3:0] out;
    logic [3:0]                  out_valid;
    logic [3:0]                  err;
    logic                        irq;
    logic [13:0]                 exp_q[$];
    logic [13:0]                 e;
    quad_tx_pkg::char_kind_e     k;
    logic [1:0]                  c;
    logic [7:0]                  d;
    logic                        bad;
    logic                        s;
    int                          failures;
    int                          n_tests;

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    tx_host_model host (.o_ref_clk(ref_clk), .o_ctrl(ctrl), .o_byte(chr),
        .o_par(par), .o_special(special));

    quad_tx_input_parity_check dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_reference_clock(ref_clk), .i_chan_input_clock(4'h0),
        .i_chan_ctrl_code(ctrl), .i_chan_char_byte(chr),
        .i_chan_odd_parity_in(par), .i_special_char_select(special),
        .i_input_clock_select(sel), .i_half_rate_select(half),
        .i_encoder_mode_setting(mode), .i_parity_check_control(par_ctl),
        .i_phase_align_reset_n(prst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(reg_wr), .i_rd(reg_rd), .o_rdata(rdata), .o_chan_out(out),
        .o_chan_out_valid(out_valid), .o_chan_error_flag(err), .o_irq(irq));

    task automatic check(input string what, input logic [31:0] ev,
                         input logic [31:0] sv);
        n_tests++;
        if (sv !== ev) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, ev, sv);
        end
    endtask : check

    task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge i_clk);
        reg_wr <= 1'b1;
        addr   <= a;
        wdata  <= v;
        @(posedge i_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : bus_wr

    task automatic bus_rd(input logic [3:0] a, input logic [31:0] ev);
        @(posedge i_clk);
        reg_rd <= 1'b1;
        addr   <= a;
        @(posedge i_clk);
        reg_rd <= 1'b0;
        #1;
        check("rdata", ev, rdata);
    endtask : bus_rd

    // Note the expected character, then present it
    task automatic one_char(input logic [1:0] m, input logic [1:0] pc);
        @(posedge i_clk);
        mode    <= m;
        par_ctl <= pc;
        repeat (8) @(posedge i_clk);
        k = (m == 2'h0) ? quad_tx_pkg::KIND_RAW : (c == 2'h0) ?
            quad_tx_pkg::KIND_DATA : (c == 2'h2) ? quad_tx_pkg::KIND_FILL :
            (c == 2'h3 && s) ? quad_tx_pkg::KIND_SYNC :
            quad_tx_pkg::KIND_SPECIAL;
        if (bad)
            k = quad_tx_pkg::KIND_VIOL;
        exp_q.push_back({bad, k, c, d});
        host.send(c, d, pc, bad, s);
        repeat (12) @(posedge i_clk);
    endtask : one_char

    always @(posedge i_clk) begin
        if (!half && out_valid[0] === 1'b1) begin
            if (exp_q.size() == 0)
                check("spare char", 32'h0, 32'h1);
            else begin
                e = exp_q.pop_front();
                for (int i = 0; i < 4; i++)
                    check("char", 32'(e), 32'({err[i], out[i]}));
            end
        end
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    initial begin
        i_rst_n  = 1'b0;
        reg_wr   = 1'b0;
        reg_rd   = 1'b0;
        addr     = 4'h0;
        wdata    = 32'h0;
        mode     = 2'h0;
        par_ctl  = 2'h0;
        sel      = 2'h0;
        half     = 1'b0;
        prst_n   = 1'b1;
        failures = 0;
        n_tests  = 0;
        void'($urandom(32'hf972));
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        bus_rd(quad_tx_pkg::ADDR_CTRL, 32'h0);
        bus_rd(quad_tx_pkg::ADDR_STATUS, 32'h0);
        bus_rd(quad_tx_pkg::ADDR_MASK, 32'h0);
        bus_rd(4'h2, 32'h0);
        $display("test registers done");
        // Every mode, both parity checks, every control code
        for (int i = 0; i < 32; i++) begin
            c   = 2'(i >> 3);
            d   = 8'($urandom);
            bad = 1'($urandom);
            s   = 1'($urandom);
            one_char(2'(i), (i & 4) != 0 ? 2'h2 : 2'h1);
        end
        bad = 1'b1;
        one_char(2'h1, 2'h1);
        for (int i = 0; i < 100 && exp_q.size() > 0; i++)
            @(posedge i_clk);
        check("queue left", 32'h0, 32'(exp_q.size()));
        $display("test characters done");
        bus_rd(quad_tx_pkg::ADDR_STATUS, 32'hf);
        check("irq masked", 32'h0, 32'(irq));
        bus_wr(quad_tx_pkg::ADDR_MASK, 32'h1);
        check("irq", 32'h1, 32'(irq));
        bus_wr(quad_tx_pkg::ADDR_STATUS, 32'hf);
        check("irq cleared", 32'h0, 32'(irq));
        bus_rd(quad_tx_pkg::ADDR_STATUS, 32'h0);
        $display("test interrupt done");
        // Buffers on, no capture: underflow, then phase reset recovery
        par_ctl <= 2'h0;
        sel     <= 2'h3;
        half    <= 1'b1;
        repeat (8) @(posedge i_clk);
        bus_rd(quad_tx_pkg::ADDR_FLAGS, 32'hff);
        repeat (2) host.send(2'h0, 8'h00, 2'h0, 1'b0, 1'b0);
        repeat (8) @(posedge i_clk);
        check("fault set", 32'hf, 32'(err));
        prst_n <= 1'b0;
        repeat (2) host.send(2'h0, 8'h00, 2'h0, 1'b0, 1'b0);
        repeat (8) @(posedge i_clk);
        prst_n <= 1'b1;
        check("fault cleared", 32'h0, 32'(err));
        $display("test buffer done");
        // Half rate self-test: 511 ticks over both reference edges
        sel <= 2'h0;
        bus_wr(quad_tx_pkg::ADDR_CTRL, 32'h1);
        repeat (255) host.send(2'h0, 8'($urandom), 2'h0, 1'b0, 1'b0);
        repeat (8) @(posedge i_clk);
        check("self-test early", 32'h0, 32'(err));
        host.send(2'h0, 8'h00, 2'h0, 1'b0, 1'b0);
        repeat (3) @(posedge i_clk);
        check("self-test pass", 32'h1, 32'(err));
        bus_rd(quad_tx_pkg::ADDR_STATUS, 32'hf10);
        $display("test self-test done");
        end_sim();
    end
endmodule : quad_tx_input_parity_check_tb_top

`default_nettype wire
